// file: rtl/vpm_pkg.sv
// Purpose: shared constants and types of the virtual partition map register bank
// Assumes: one core clock, synchronous active-low reset
// Notes:   holds the mapping registers for virtual identifiers 12 to 23
package vpm_pkg;
	// system-register encoding of the mapping registers
	localparam logic [1:0] ENC_OP0       = 2'h3;
	localparam logic [2:0] ENC_OP1       = 3'h4;
	localparam logic [3:0] ENC_CRN       = 4'ha;
	localparam logic [3:0] ENC_CRM       = 4'h6;
	localparam logic [2:0] ENC_OP2_FIRST = 3'h3;

	// register indices held by this bank
	localparam logic [2:0] FIRST_MAP_IDX = 3'h3;
	localparam int         NUM_MAP_REGS  = 3;
	localparam logic [1:0] LAST_SLOT     = 2'h2;
	localparam logic [13:0] FIRST_VREG   = 14'h0003;
	localparam logic [13:0] LAST_VREG    = 14'h0005;

	// register and field layout
	localparam int REG_W   = 64;
	localparam int FIELD_W = 16;
	localparam int VALID_W = 32;

	// nested redirection offsets, one per slot
	localparam logic [11:0] NV_OFF_12_TO_15 = 12'h958;
	localparam logic [11:0] NV_OFF_16_TO_19 = 12'h960;
	localparam logic [11:0] NV_OFF_20_TO_23 = 12'h968;

	// trap syndrome class
	localparam logic [5:0] TRAP_SYNDROME = 6'h18;

	// privilege level codes
	localparam logic [1:0] LEVEL_0 = 2'h0;
	localparam logic [1:0] LEVEL_1 = 2'h1;
	localparam logic [1:0] LEVEL_2 = 2'h2;
	localparam logic [1:0] LEVEL_3 = 2'h3;

	// reset values of the answer and translation registers
	localparam logic [11:0] OFFSET_RST = 12'h000;
	localparam logic [5:0]  SYND_RST   = 6'h00;
	localparam logic [15:0] PID_RST    = 16'h0000;

	// result of one system-register access
	typedef enum logic [2:0] {
		ACC_NONE,
		ACC_DONE,
		ACC_UNDEF,
		ACC_TRAP,
		ACC_REDIRECT
	} acc_outcome_e;
endpackage

// file: rtl/map_store_if.sv
// Purpose: carrier between the control logic and the mapping storage
// Assumes: all signals on the core clock
// Notes:   read data come back one enabled edge after the read enable
interface map_store_if;
	logic        wr_en;
	logic [1:0]  wr_slot;
	logic [63:0] wr_data;
	logic        rd_en;
	logic [1:0]  rd_slot;
	logic [63:0] rd_data;
	logic        xl_en;
	logic [1:0]  xl_slot;
	logic [63:0] xl_data;

	modport ctrl (output wr_en, wr_slot, wr_data, rd_en, rd_slot, xl_en, xl_slot,
		input rd_data, xl_data);
	modport store (input wr_en, wr_slot, wr_data, rd_en, rd_slot, xl_en, xl_slot,
		output rd_data, xl_data);
endinterface

// file: rtl/map_store.sv
// Purpose: storage of the three 64-bit mapping registers
// Assumes: slots are below the register count when enabled
// Notes:   cells carry no reset, their content is unknown until written
module map_store (
	// clock
	input wire logic        ref_clk,
	input wire logic        clk_en,
	// storage port
	map_store_if.store      mem
);
	logic [63:0] cells [vpm_pkg::NUM_MAP_REGS];

	// whole-register write and two registered read ports
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (mem.wr_en)
				cells[mem.wr_slot] <= mem.wr_data;
			if (mem.rd_en)
				mem.rd_data <= cells[mem.rd_slot];
			if (mem.xl_en)
				mem.xl_data <= cells[mem.xl_slot];
		end
	end
endmodule

// file: rtl/reg_present.sv
// Purpose: tells whether one mapping register exists
// Assumes: highest index is a static configuration level
// Notes:   one instance per register of the bank
module reg_present #(
	parameter logic [2:0] REG_IDX = 3'h3
) (
	// configuration
	input wire logic        hyp_control_present,
	input wire logic [2:0]  highest_map_index,
	// result
	output logic            present
);
	// present when hypervisor control exists and the index reaches it
	assign present = hyp_control_present && (highest_map_index >= REG_IDX);
endmodule

// file: rtl/virtual_partition_id_map_regs.sv
// Purpose: virtual-to-physical partition map registers for virtual ids 12 to 23
// Assumes: inputs synchronous to ref_clk, configuration levels held steady
// Notes:   access answer one edge after request, translation two edges after

module virtual_partition_id_map_regs (
	// clock, reset, enable
	input wire logic         ref_clk,
	input wire logic         nrst,
	input wire logic         clk_en,
	// system-register access request
	input wire logic         req_valid,
	input wire logic         req_write,
	input wire logic [1:0]   req_op0,
	input wire logic [2:0]   req_op1,
	input wire logic [3:0]   req_crn,
	input wire logic [3:0]   req_crm,
	input wire logic [2:0]   req_op2,
	input wire logic [1:0]   req_level,
	input wire logic [63:0]  req_wdata,
	// configuration levels
	input wire logic         level2_enabled,
	input wire logic         level3_present,
	input wire logic         hyp_control_present,
	input wire logic [2:0]   highest_map_index,
	input wire logic         nested_virt_enable,
	input wire logic         nested_virt_redirect,
	input wire logic         trap_lower_levels,
	input wire logic         level1_map_enable,
	input wire logic         level0_map_enable,
	input wire logic [31:0]  map_entry_valid_bits,
	// access answer
	output logic             resp_valid,
	output logic [2:0]       resp_outcome,
	output logic [63:0]      resp_rdata,
	output logic [1:0]       trap_target_level,
	output logic [5:0]       trap_syndrome,
	output logic [11:0]      redirect_offset,
	// translation request and result
	input wire logic         xlat_req,
	input wire logic         xlat_from_level1,
	input wire logic [15:0]  xlat_vid,
	output logic             xlat_done,
	output logic             xlat_mapped,
	output logic [15:0]      xlat_pid
);
	map_store_if mem_if ();

	// presence of each register of the bank
	logic [vpm_pkg::NUM_MAP_REGS-1:0] present_vec;

	genvar gi;
	generate
		for (gi = 0; gi < vpm_pkg::NUM_MAP_REGS; gi++)
		begin : g_present
			reg_present #(
				.REG_IDX (3'(vpm_pkg::FIRST_MAP_IDX + 3'(gi)))
			) u_present (
				.hyp_control_present (hyp_control_present),
				.highest_map_index   (highest_map_index),
				.present             (present_vec[gi])
			);
		end
	endgenerate

	// storage of the three mapping registers
	map_store u_store (
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.mem     (mem_if.store)
	);

	// encoding decode
	wire        enc_base;
	wire [2:0]  op2_off;
	wire        enc_hit;
	wire [1:0]  acc_slot;
	wire        slot_present;

	assign enc_base     = (req_op0 == vpm_pkg::ENC_OP0) && (req_op1 == vpm_pkg::ENC_OP1)
		&& (req_crn == vpm_pkg::ENC_CRN) && (req_crm == vpm_pkg::ENC_CRM);
	assign op2_off      = req_op2 - vpm_pkg::ENC_OP2_FIRST;
	assign enc_hit      = enc_base && (req_op2 >= vpm_pkg::ENC_OP2_FIRST)
		&& (op2_off[1:0] <= vpm_pkg::LAST_SLOT) && (op2_off[2] == 1'b0);
	assign acc_slot     = enc_hit ? op2_off[1:0] : 2'h0;
	assign slot_present = present_vec[acc_slot];

	// permission decode of one access
	wire                  trap_to_3;
	wire                  l1_redirect;
	wire                  l1_trap;
	wire                  l2_trap;
	vpm_pkg::acc_outcome_e l1_outcome;
	vpm_pkg::acc_outcome_e level_outcome;
	vpm_pkg::acc_outcome_e outcome_nxt;
	wire [1:0]            trap_level_nxt;
	wire [11:0]           offset_nxt;

	assign trap_to_3   = level3_present && trap_lower_levels;
	assign l1_redirect = level2_enabled && nested_virt_redirect && nested_virt_enable;
	assign l1_trap     = level2_enabled && nested_virt_enable && !l1_redirect;
	assign l2_trap     = trap_to_3;

	// level 1 picks redirect, trap or undefined in that order
	assign l1_outcome = l1_redirect ? vpm_pkg::ACC_REDIRECT
		: l1_trap ? vpm_pkg::ACC_TRAP
		: vpm_pkg::ACC_UNDEF;

	// outcome by current privilege level
	assign level_outcome = (req_level == vpm_pkg::LEVEL_0) ? vpm_pkg::ACC_UNDEF
		: (req_level == vpm_pkg::LEVEL_1) ? l1_outcome
		: (req_level == vpm_pkg::LEVEL_2) ? (l2_trap ? vpm_pkg::ACC_TRAP : vpm_pkg::ACC_DONE)
		: vpm_pkg::ACC_DONE;

	// absent registers are undefined before any level check
	assign outcome_nxt = !enc_hit ? vpm_pkg::ACC_NONE
		: !slot_present ? vpm_pkg::ACC_UNDEF
		: level_outcome;

	// trap target: level 3 when trapping lower, else level 2
	assign trap_level_nxt = ((req_level == vpm_pkg::LEVEL_1) && !trap_to_3)
		? vpm_pkg::LEVEL_2 : vpm_pkg::LEVEL_3;

	// nested memory offset per register
	assign offset_nxt = (acc_slot == 2'h0) ? vpm_pkg::NV_OFF_12_TO_15
		: (acc_slot == 2'h1) ? vpm_pkg::NV_OFF_16_TO_19
		: vpm_pkg::NV_OFF_20_TO_23;

	// storage access for a permitted direct access
	wire acc_take;
	wire acc_done;

	assign acc_take = req_valid && clk_en;
	assign acc_done = acc_take && (outcome_nxt == vpm_pkg::ACC_DONE);

	assign mem_if.wr_en   = acc_done && req_write;
	assign mem_if.wr_slot = acc_slot;
	assign mem_if.wr_data = req_wdata;
	assign mem_if.rd_en   = acc_done && !req_write;
	assign mem_if.rd_slot = acc_slot;

	// answer registers
	logic                  resp_valid_r;
	vpm_pkg::acc_outcome_e outcome_r;
	logic [1:0]            trap_level_r;
	logic [5:0]            syndrome_r;
	logic [11:0]           offset_r;

	// capture the answer one edge after the request
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			resp_valid_r <= 1'b0;
			outcome_r    <= vpm_pkg::ACC_NONE;
			trap_level_r <= vpm_pkg::LEVEL_0;
			syndrome_r   <= vpm_pkg::SYND_RST;
			offset_r     <= vpm_pkg::OFFSET_RST;
		end
		else if (clk_en)
		begin
			resp_valid_r <= req_valid;
			if (req_valid)
			begin
				outcome_r    <= outcome_nxt;
				trap_level_r <= (outcome_nxt == vpm_pkg::ACC_TRAP) ? trap_level_nxt : vpm_pkg::LEVEL_0;
				syndrome_r   <= (outcome_nxt == vpm_pkg::ACC_TRAP) ? vpm_pkg::TRAP_SYNDROME
					: vpm_pkg::SYND_RST;
				offset_r     <= (outcome_nxt == vpm_pkg::ACC_REDIRECT) ? offset_nxt
					: vpm_pkg::OFFSET_RST;
			end
		end
	end

	// read data holds the last direct read
	logic rdata_seen_r;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			rdata_seen_r <= 1'b0;
		else if (clk_en && mem_if.rd_en)
			rdata_seen_r <= 1'b1;
	end

	assign resp_valid        = resp_valid_r;
	assign resp_outcome      = outcome_r;
	assign resp_rdata        = rdata_seen_r ? mem_if.rd_data : {vpm_pkg::REG_W{1'b0}};
	assign trap_target_level = trap_level_r;
	assign trap_syndrome     = syndrome_r;
	assign redirect_offset   = offset_r;

	// translation stage 1: locate register and field of the virtual id
	wire [13:0] xl_vreg;
	wire        xl_in_bank;
	wire [13:0] xl_slot_wide;
	wire [1:0]  xl_slot;
	wire        xl_enabled;
	wire        xl_entry_valid;
	wire        xl_use;

	assign xl_vreg        = xlat_vid[15:2];
	assign xl_in_bank     = (xl_vreg >= vpm_pkg::FIRST_VREG) && (xl_vreg <= vpm_pkg::LAST_VREG);
	assign xl_slot_wide   = xl_vreg - vpm_pkg::FIRST_VREG;
	assign xl_slot        = xl_in_bank ? xl_slot_wide[1:0] : 2'h0;
	assign xl_enabled     = xlat_from_level1 ? level1_map_enable : level0_map_enable;
	assign xl_entry_valid = map_entry_valid_bits[xlat_vid[4:0]];
	assign xl_use         = xl_in_bank && present_vec[xl_slot] && level2_enabled
		&& xl_enabled && xl_entry_valid;

	assign mem_if.xl_en   = xlat_req && clk_en;
	assign mem_if.xl_slot = xl_slot;

	// stage 1 pipeline registers
	logic        xs1_valid_r;
	logic        xs1_use_r;
	logic [1:0]  xs1_field_r;
	logic [15:0] xs1_vid_r;

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			xs1_valid_r <= 1'b0;
			xs1_use_r   <= 1'b0;
			xs1_field_r <= 2'h0;
			xs1_vid_r   <= vpm_pkg::PID_RST;
		end
		else if (clk_en)
		begin
			xs1_valid_r <= xlat_req;
			if (xlat_req)
			begin
				xs1_use_r   <= xl_use;
				xs1_field_r <= xlat_vid[1:0];
				xs1_vid_r   <= xlat_vid;
			end
		end
	end

	// stage 2: pick the 16-bit field, highest id in the top field
	wire [15:0] xl_field;

	assign xl_field = (xs1_field_r == 2'h3) ? mem_if.xl_data[63:48]
		: (xs1_field_r == 2'h2) ? mem_if.xl_data[47:32]
		: (xs1_field_r == 2'h1) ? mem_if.xl_data[31:16]
		: mem_if.xl_data[15:0];

	logic        xlat_done_r;
	logic        xlat_mapped_r;
	logic [15:0] xlat_pid_r;

	// unmapped ids pass through unchanged
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			xlat_done_r   <= 1'b0;
			xlat_mapped_r <= 1'b0;
			xlat_pid_r    <= vpm_pkg::PID_RST;
		end
		else if (clk_en)
		begin
			xlat_done_r <= xs1_valid_r;
			if (xs1_valid_r)
			begin
				xlat_mapped_r <= xs1_use_r;
				xlat_pid_r    <= xs1_use_r ? xl_field : xs1_vid_r;
			end
		end
	end

	assign xlat_done   = xlat_done_r;
	assign xlat_mapped = xlat_mapped_r;
	assign xlat_pid    = xlat_pid_r;
endmodule

// file: verification/vpm_monitor.sv
// Purpose: concurrent checks on the ports of the map register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes:   encoding, presence and outcome expectations rebuilt from inputs
module vpm_monitor (
	// clock, reset, enable
	input wire logic        ref_clk, nrst, clk_en,
	// access request
	input wire logic        req_valid, req_write,
	input wire logic [1:0]  req_op0, req_level,
	input wire logic [2:0]  req_op1, req_op2,
	input wire logic [3:0]  req_crn, req_crm,
	input wire logic [63:0] req_wdata,
	// configuration
	input wire logic        level2_enabled, level3_present, hyp_control_present,
	input wire logic [2:0]  highest_map_index,
	input wire logic        nested_virt_enable, nested_virt_redirect, trap_lower_levels,
	// answer
	input wire logic        resp_valid,
	input wire logic [2:0]  resp_outcome,
	input wire logic [63:0] resp_rdata,
	input wire logic [1:0]  trap_target_level,
	input wire logic [5:0]  trap_syndrome,
	input wire logic [11:0] redirect_offset,
	// translation
	input wire logic        xlat_req, xlat_done, xlat_mapped,
	input wire logic [15:0] xlat_vid, xlat_pid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// request decode: our encoding, register present, expected trap target and offset
	wire        hit  = req_valid && clk_en && req_op0 == vpm_pkg::ENC_OP0 && req_op1 == vpm_pkg::ENC_OP1
		&& req_crn == vpm_pkg::ENC_CRN && req_crm == vpm_pkg::ENC_CRM && req_op2 >= 3'h3 && req_op2 <= 3'h5;
	wire        pres = hyp_control_present && highest_map_index >= req_op2;
	wire [1:0]  tgt  = (level3_present && trap_lower_levels) ? 2'h3 : 2'h2;
	wire [11:0] offx = 12'h958 + {6'h00, req_op2 - 3'h3, 3'h0};

	// a direct write followed by a direct read of the same register
	sequence s_wr;
		hit && pres && req_level == 2'h3 && req_write;
	endsequence
	sequence s_rd_same;
		hit && pres && req_level == 2'h3 && !req_write && req_op2 == $past(req_op2, 2);
	endsequence

	a_answer_next: assert property (req_valid && clk_en |=> resp_valid)
		else $error("no answer after request");
	a_idle_quiet: assert property (!req_valid && clk_en |=> !resp_valid)
		else $error("answer without request");
	a_level0_undef: assert property (hit && req_level == 2'h0 |=> resp_outcome == vpm_pkg::ACC_UNDEF)
		else $error("level 0 access not undefined");
	a_absent_undef: assert property (hit && !pres |=> resp_outcome == vpm_pkg::ACC_UNDEF)
		else $error("absent register not undefined");
	a_level3_done: assert property (hit && pres && req_level == 2'h3 |=> resp_outcome == vpm_pkg::ACC_DONE)
		else $error("level 3 access not done");
	a_trap_upper: assert property (hit && pres && req_level == 2'h2 && level3_present && trap_lower_levels
		|=> resp_outcome == vpm_pkg::ACC_TRAP && trap_target_level == 2'h3 && trap_syndrome == 6'h18)
		else $error("level 2 trap wrong");
	a_nested_redirect: assert property (hit && pres && req_level == 2'h1 && level2_enabled
		&& nested_virt_enable && nested_virt_redirect
		|=> resp_outcome == vpm_pkg::ACC_REDIRECT && redirect_offset == $past(offx))
		else $error("redirect wrong");
	a_nested_trap: assert property (hit && pres && req_level == 2'h1 && level2_enabled
		&& nested_virt_enable && !nested_virt_redirect
		|=> resp_outcome == vpm_pkg::ACC_TRAP && trap_target_level == $past(tgt) && trap_syndrome == 6'h18)
		else $error("nested trap wrong");
	a_write_back: assert property (s_wr ##2 s_rd_same |=> resp_rdata == $past(req_wdata, 3))
		else $error("read data differ from write");
	a_xlat_pipe: assert property (xlat_req && clk_en ##1 clk_en |=> xlat_done)
		else $error("translation result late");
	a_no_level2: assert property (xlat_req && clk_en && !level2_enabled ##1 clk_en
		|=> !xlat_mapped && xlat_pid == $past(xlat_vid, 2))
		else $error("mapped with level 2 off");
endmodule

bind virtual_partition_id_map_regs vpm_monitor i_vpm_monitor (.*);

// file: verification/virtual_partition_id_map_regs_bench.sv
// Purpose: self-checking bench of the map register bank
// Assumes: clock enable held high, encoding fields fixed to the bank
// Notes:   outcome table first, then storage and translation cases
module virtual_partition_id_map_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [1:0] lv; logic [2:0] op2, hmax; logic hyp, l2, l3, tl, nv, nv2;
		logic [2:0] oc; logic [1:0] tgt; logic [11:0] off;
	} row_s;
	// level, op2, max index, hyp, l2 on, l3, trap lower, nv, nv2 -> outcome, target, offset
	row_s rows [17] = '{
		'{0,3,5,1,1,1,0,0,0,2,0,0}, '{3,3,2,1,1,1,0,0,0,2,0,0}, '{3,4,3,1,1,1,0,0,0,2,0,0},
		'{3,4,4,1,1,1,0,0,0,1,0,0}, '{3,5,4,1,1,1,0,0,0,2,0,0}, '{3,5,7,1,1,1,0,0,0,1,0,0},
		'{3,5,7,0,1,1,0,0,0,2,0,0}, '{3,3,0,1,1,1,0,0,0,2,0,0}, '{1,3,5,1,1,1,0,1,1,4,0,12'h958},
		'{1,4,5,1,1,1,0,1,1,4,0,12'h960}, '{1,5,5,1,1,1,0,1,1,4,0,12'h968}, '{1,4,5,1,1,1,1,1,0,3,3,0},
		'{1,4,5,1,1,0,1,1,0,3,2,0}, '{1,4,5,1,0,1,0,1,1,2,0,0}, '{2,4,5,1,1,1,1,0,0,3,3,0},
		'{2,4,5,1,1,1,0,0,0,1,0,0}, '{3,6,7,1,1,1,0,0,0,0,0,0}};
	logic [63:0] dat [3] = '{64'h1a1b_1c1d_1e1f_1011, 64'h2a2b_2c2d_2e2f_2021, 64'h3a3b_3c3d_3e3f_3031};
	logic ref_clk = 0, nrst = 0, clk_en = 1, req_valid = 0, req_write = 0;
	logic [1:0] req_op0 = vpm_pkg::ENC_OP0, req_level = 0;
	logic [2:0] req_op1 = vpm_pkg::ENC_OP1, req_op2 = 0, highest_map_index = 5;
	logic [3:0] req_crn = vpm_pkg::ENC_CRN, req_crm = vpm_pkg::ENC_CRM;
	logic [63:0] req_wdata = 0;
	logic level2_enabled = 1, level3_present = 1, hyp_control_present = 1, nested_virt_enable = 0;
	logic nested_virt_redirect = 0, trap_lower_levels = 0, level1_map_enable = 1, level0_map_enable = 0;
	logic [31:0] map_entry_valid_bits = 32'hffff_ffff;
	logic resp_valid, xlat_done, xlat_mapped, xlat_req = 0, xlat_from_level1 = 0;
	logic [2:0] resp_outcome;
	logic [63:0] resp_rdata;
	logic [1:0] trap_target_level;
	logic [5:0] trap_syndrome;
	logic [11:0] redirect_offset;
	logic [15:0] xlat_vid = 0, xlat_pid;
	int n_fail = 0, samples_checked = 0;

	virtual_partition_id_map_regs i_virtual_partition_id_map_regs (.*);

	// clock at 40 MHz
	always #12.5 ref_clk = ~ref_clk;

	// one comparison, reported at once on mismatch
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	// one register access, request held until the taking edge
	task acc(input logic [1:0] lv, input logic [2:0] op2, input logic wr, input logic [63:0] wd);
		@(posedge ref_clk);
		#2 req_valid = 1; req_level = lv; req_op2 = op2; req_write = wr; req_wdata = wd;
		@(posedge ref_clk);
		#2 req_valid = 0;
		chk("resp_valid", 1, resp_valid);
	endtask

	// one translation, result two edges after the request
	task xl(input logic [15:0] v, input logic f1, input logic m, input logic [15:0] p);
		@(posedge ref_clk);
		#2 xlat_req = 1; xlat_vid = v; xlat_from_level1 = f1;
		@(posedge ref_clk);
		#2 xlat_req = 0;
		@(posedge ref_clk);
		#2 chk("xlat_done", 1, xlat_done);
		chk("xlat_mapped", m, xlat_mapped);
		chk("xlat_pid", p, xlat_pid);
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog well beyond the roughly 80 cycles the tests need
	initial
	begin
		repeat (2000) @(posedge ref_clk);
		n_fail++;
		complete_run;
	end

	initial
	begin
		repeat (5) @(posedge ref_clk);
		#2 nrst = 1;
		chk("resp_outcome", 0, resp_outcome);
		chk("resp_rdata", 0, resp_rdata);
		// outcome table
		foreach (rows[i])
		begin
			{hyp_control_present, level2_enabled, level3_present} = {rows[i].hyp, rows[i].l2, rows[i].l3};
			{trap_lower_levels, nested_virt_enable, nested_virt_redirect} = {rows[i].tl, rows[i].nv, rows[i].nv2};
			highest_map_index = rows[i].hmax;
			acc(rows[i].lv, rows[i].op2, 0, 0);
			chk("resp_outcome", rows[i].oc, resp_outcome);
			chk("trap_target_level", rows[i].tgt, trap_target_level);
			chk("trap_syndrome", rows[i].oc == 3 ? 6'h18 : 6'h00, trap_syndrome);
			chk("redirect_offset", rows[i].off, redirect_offset);
		end
		// whole-register write then read back, each register
		{hyp_control_present, level2_enabled, level3_present, trap_lower_levels} = 4'hc;
		{nested_virt_enable, nested_virt_redirect, highest_map_index} = 5'h05;
		for (int k = 0; k < 3; k++)
		begin
			acc(3, 3'(k + 3), 1, dat[k]);
			acc(3, 3'(k + 3), 0, 0);
			chk("resp_rdata", dat[k], resp_rdata);
		end
		// trapped write leaves the register unchanged, level 3 must exist to take the trap
		{level3_present, trap_lower_levels} = 2'h3;
		acc(2, 4, 1, ~dat[1]);
		chk("resp_outcome", 3, resp_outcome);
		chk("trap_target_level", 3, trap_target_level);
		trap_lower_levels = 0;
		acc(3, 4, 0, 0);
		chk("resp_rdata", dat[1], resp_rdata);
		// translation: field select, enables, valid bits, level 2, presence
		xl(17, 1, 1, dat[1][31:16]);
		xl(22, 1, 1, dat[2][47:32]);
		xl(15, 1, 1, dat[0][63:48]);
		xl(17, 0, 0, 17);
		map_entry_valid_bits[17] = 0;
		xl(17, 1, 0, 17);
		map_entry_valid_bits[17] = 1;
		level2_enabled = 0;
		xl(17, 1, 0, 17);
		level2_enabled = 1;
		highest_map_index = 4;
		xl(22, 1, 0, 22);
		level0_map_enable = 1;
		xl(16, 0, 1, dat[1][15:0]);
		complete_run;
	end
endmodule
